// ==== pkg/uvep_pkg.sv ====
// package: constants and carrier types for the eprom programmer/reader
package uvep_pkg;
  localparam int ADDR_W         = 11;
  localparam int DATA_W         = 8;
  localparam int WORDS          = 2048;
  localparam int CLK_MHZ        = 125;
  // times in their own units
  localparam int PULSE_US       = 1000;   // default pulse, within 100..1000 us
  localparam int PULSE_MIN_US   = 100;
  localparam int PULSE_MAX_US   = 1000;
  localparam int GAP_US         = 1;      // least wait after a pulse
  localparam int SETUP_US       = 10;     // setup before a pulse
  localparam int INVALID_US     = 10;     // output invalid after leaving write mode
  localparam int TOTAL_MS       = 100;    // least accumulated pulse time per word
  localparam int READ_NS        = 450;    // read cycle / access time
  localparam int RELEASE_NS     = 1000;   // data hold after pulse end
  // cycle counts: least times round up
  localparam int GAP_CYC        = (GAP_US * CLK_MHZ);
  localparam int SETUP_CYC      = (SETUP_US * CLK_MHZ);
  localparam int INVALID_CYC    = (INVALID_US * CLK_MHZ);
  localparam int READ_CYC       = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int RELEASE_CYC    = (RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC       = 4;      // edges from data pin to synchroniser output
  localparam int PULSE_CYC      = PULSE_US * CLK_MHZ;
  localparam int LOOPS_DEF      = (TOTAL_MS * 1000 + PULSE_US - 1) / PULSE_US;
  localparam int CNT_W          = 24;
  localparam int LOOP_W         = 16;
  localparam logic [DATA_W-1:0] ERASED = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 11'h7FF;

  // pins toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic              select_n;           // read select, held low through write mode; the pulse itself is write_pulse
    logic              write_pulse;
    logic              write_mode_enable;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_n;          // low while we drive data_lines
  } uvep_pins_t;

  typedef enum logic [1:0] {UVEP_OK, UVEP_BUSY, UVEP_VERIFY_FAIL} uvep_status_t;
endpackage

// ==== rtl/uvep_sync.sv ====
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module uvep_sync #(
  parameter int W = 8
) (
  // clocking
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_q = q;
    for (int i = 0; i < W; i++)
    begin
      // s1 feeds only s2, so a metastable first stage never reaches logic
      if (s2[i] == s3[i])
        next_q[i] = s3[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end
    else if (ce)
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/uvep_host.sv ====
// host controller: reads words and runs full programming passes on the eprom
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - address bits 0..10 pick one word
// RQ2 - select low: device drives read data
// RQ3 - select high: device data lines float
// RQ4 - write mode: select pin is pulse only; select_n is held low through write mode and the pulse goes on write_pulse
// RQ5 - read data holds until address/select change
// RQ6 - erased reads ones; only ones cleared
// RQ7 - charge builds over many pulses per word
// RQ8 - hold write mode enable whole sequence
// RQ9 - pulse 0.1 to 1.0 ms per word
// RQ10 - wait 1 us, then next address
// RQ11 - start each pass at address zero
// RQ12 - all words, N passes, N*pulse>=100ms
// RQ13 - drop pulse before write mode enable
// RQ14 - release data before changing address; data stays driven as the address steps, released only after the last pass
// RQ15 - ignore outputs 10 us after exit
// RQ16 - 10 us setup before each pulse
module uvep_host
  import uvep_pkg::*;
#(
  parameter int PULSE_CYCLES = uvep_pkg::PULSE_CYC,
  parameter int SETUP_CYCLES = uvep_pkg::SETUP_CYC,
  parameter int INVALID_CYCLES = uvep_pkg::INVALID_CYC,
  parameter int LOOPS        = uvep_pkg::LOOPS_DEF
) (
  // clocking
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       ce,
  // read request
  input  wire logic                       rd_req,
  input  wire logic [uvep_pkg::ADDR_W-1:0] rd_addr,
  output logic                            rd_valid,
  output logic      [uvep_pkg::DATA_W-1:0] rd_data,
  // program request and image source
  input  wire logic                       prog_start,
  output logic                            img_req,
  output logic      [uvep_pkg::ADDR_W-1:0] img_addr,
  input  wire logic [uvep_pkg::DATA_W-1:0] img_data,
  // status
  output logic                            busy,
  output logic                            prog_done,
  // device pins
  output uvep_pkg::uvep_pins_t            pins,
  input  wire logic [uvep_pkg::DATA_W-1:0] data_lines_in
);
  import uvep_pkg::*;

  typedef enum {
    S_IDLE, S_RD_SETUP, S_RD_WAIT, S_PE_SETUP, S_FETCH, S_SETUP, S_PULSE,
    S_GAP, S_RELEASE, S_EXIT_WAIT
  } uvep_state_t;

  uvep_state_t       state;
  uvep_state_t       next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [LOOP_W-1:0] loop;
  logic [LOOP_W-1:0] next_loop;
  uvep_pins_t        next_pins;
  logic              next_rd_valid;
  logic [DATA_W-1:0] next_rd_data;
  logic              next_img_req;
  logic [ADDR_W-1:0] next_img_addr;
  logic              next_busy;
  logic              next_prog_done;
  logic [DATA_W-1:0] data_sync;

  // pins come from another timing world, resynchronise them
  uvep_sync #(.W(DATA_W)) u_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .d    (data_lines_in),
    .q    (data_sync)
  );

  function automatic logic [CNT_W-1:0] to_cnt(input int n);
    to_cnt = CNT_W'(n);
  endfunction

  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_loop      = loop;
    next_pins      = pins;
    next_rd_valid  = 1'b0;
    next_rd_data   = rd_data;
    next_img_req   = 1'b0;
    next_img_addr  = img_addr;
    next_busy      = busy;
    next_prog_done = 1'b0;
    if (cnt != '0)
      next_cnt = cnt - 1'b1;
    unique case (state)
      S_IDLE:
      begin
        next_busy = 1'b0;
        if (prog_start)
        begin
          next_busy                   = 1'b1;
          next_pins.write_mode_enable = 1'b1;                   // RQ8
          next_pins.select_n          = 1'b0;                   // RQ4
          next_pins.word_address      = ADDR_ZERO;              // RQ11
          next_loop                   = '0;
          next_cnt                    = to_cnt(SETUP_CYCLES);   // RQ16
          next_state                  = S_PE_SETUP;
        end
        else if (rd_req)
        begin
          next_busy              = 1'b1;
          next_pins.word_address = rd_addr;                     // RQ1
          next_pins.select_n     = 1'b0;                        // RQ2
          // access time plus every synchroniser stage, else a stale byte is taken
          next_cnt               = to_cnt(READ_CYC + SYNC_CYC);
          next_state             = S_RD_SETUP;
        end
      end
      S_RD_SETUP:
        if (cnt == '0)
          next_state = S_RD_WAIT;
      S_RD_WAIT:
      begin
        // data is stable while address and select stay put
        next_rd_data       = data_sync;                         // RQ5
        next_rd_valid      = 1'b1;
        next_pins.select_n = 1'b1;                              // RQ3
        next_state         = S_IDLE;
      end
      S_PE_SETUP:
      begin
        next_img_req  = 1'b1;
        next_img_addr = pins.word_address;
        next_state    = S_FETCH;
      end
      S_FETCH:
      begin
        // image source answers in the same cycle that img_req is high
        next_pins.data_out  = img_data;                         // RQ6
        next_pins.data_oe_n = 1'b0;
        next_cnt            = to_cnt(SETUP_CYCLES);             // RQ16
        next_state          = S_SETUP;
      end
      S_SETUP:
        if (cnt == '0)
        begin
          next_pins.write_pulse = 1'b1;                         // RQ9
          // load one less: the count runs to zero once more, so the width is exact
          next_cnt              = to_cnt(PULSE_CYCLES - 1);
          next_state            = S_PULSE;
        end
      S_PULSE:
        if (cnt == '0)
        begin
          next_pins.write_pulse = 1'b0;                         // RQ13
          next_cnt              = to_cnt(RELEASE_CYC > GAP_CYC ? RELEASE_CYC : GAP_CYC);
          next_state            = S_GAP;                        // RQ10
        end
      S_GAP:
        if (cnt == '0)
        begin
          if (pins.word_address != ADDR_LAST)
          begin
            next_pins.word_address = pins.word_address + 1'b1;  // RQ10
            next_state             = S_PE_SETUP;
          end
          else if (loop != LOOP_W'(LOOPS - 1))
          begin
            // every pass adds charge to the same cells
            next_loop              = loop + 1'b1;               // RQ7
            next_pins.word_address = ADDR_ZERO;                 // RQ11
            next_state             = S_PE_SETUP;                // RQ12
          end
          else
          begin
            next_pins.data_oe_n = 1'b1;                         // RQ14
            next_state          = S_RELEASE;
          end
        end
      S_RELEASE:
      begin
        // pulse is already low, address untouched until data released
        next_pins.write_mode_enable = 1'b0;                     // RQ13
        next_pins.select_n          = 1'b1;
        next_cnt                    = to_cnt(INVALID_CYCLES);   // RQ15
        next_state                  = S_EXIT_WAIT;
      end
      S_EXIT_WAIT:
        if (cnt == '0)
        begin
          next_prog_done = 1'b1;
          next_state     = S_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state     <= S_IDLE;
      cnt       <= '0;
      loop      <= '0;
      pins      <= '{word_address: ADDR_ZERO, select_n: 1'b1, write_pulse: 1'b0,
                     write_mode_enable: 1'b0, data_out: ERASED, data_oe_n: 1'b1};
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      img_req   <= 1'b0;
      img_addr  <= '0;
      busy      <= 1'b0;
      prog_done <= 1'b0;
    end
    else if (ce)
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      loop      <= next_loop;
      pins      <= next_pins;
      rd_valid  <= next_rd_valid;
      rd_data   <= next_rd_data;
      img_req   <= next_img_req;
      img_addr  <= next_img_addr;
      busy      <= next_busy;
      prog_done <= next_prog_done;
    end
  end
endmodule
`default_nettype wire

// ==== verif/uvep_host_assertions.sv ====
// concurrent checks on the eprom host pins and read handshake
`timescale 1ns/1ps
`default_nettype none
module uvep_host_assertions
  import uvep_pkg::*;
#(
  parameter int PULSE_CYCLES = 4
) (
  // clocking
  input wire logic                 clk,
  input wire logic                 srst,
  // handshakes
  input wire logic                 rd_req,
  input wire logic                 prog_start,
  input wire logic                 rd_valid,
  input wire logic                 busy,
  // device pins
  input wire uvep_pkg::uvep_pins_t pins
);
  int hi_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // counts the high cycles of a pulse, too long for a repetition
  always_ff @(posedge clk)
    hi_cnt <= (srst || !pins.write_pulse) ? 0 : hi_cnt + 1;
  property p_pulse_mode;
    pins.write_pulse |-> pins.write_mode_enable && !pins.data_oe_n;
  endproperty
  a_pulse_mode: assert property (p_pulse_mode) else $error("pulse outside write mode");
  property p_pulse_width;
    $fell(pins.write_pulse) |-> hi_cnt == PULSE_CYCLES;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  property p_pulse_hold;
    pins.write_pulse |-> $stable(pins.word_address) && $stable(pins.data_out);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("moved in pulse");
  property p_gap;
    $fell(pins.write_pulse) |-> $stable(pins.word_address) [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("address moved in gap");
  property p_start_zero;
    $rose(pins.write_mode_enable) |-> pins.word_address == ADDR_ZERO;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("pass not at zero");
  property p_exit_order;
    $fell(pins.write_mode_enable) |-> !pins.write_pulse && $past(pins.data_oe_n);
  endproperty
  a_exit_order: assert property (p_exit_order) else $error("bad exit order");
  property p_no_clash;
    !pins.data_oe_n |-> pins.write_mode_enable;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("drive in read mode");
  property p_read_answer;
    rd_req && !busy && !prog_start |=> ##[1:80] rd_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read late");
  property p_read_end;
    rd_valid |-> pins.select_n && !pins.write_mode_enable;
  endproperty
  a_read_end: assert property (p_read_end) else $error("still selected");
  c_read: cover property (rd_valid);
  c_pulse: cover property ($fell(pins.write_pulse));
  c_enter: cover property ($rose(pins.write_mode_enable));
endmodule
bind uvep_host uvep_host_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.clk(clk),
  .srst(srst), .rd_req(rd_req), .prog_start(prog_start), .rd_valid(rd_valid),
  .busy(busy), .pins(pins));
`default_nettype wire

// ==== verif/uvep_dev.sv ====
// behavioural model of the erasable memory on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module uvep_dev
  import uvep_pkg::*;
(
  // pins from the host
  input  wire logic                       clk,
  input  wire uvep_pkg::uvep_pins_t       pins,
  input  wire logic [uvep_pkg::DATA_W-1:0] data_lines,
  // device drive of the data lines
  output logic      [uvep_pkg::DATA_W-1:0] dev_q
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [ADDR_W-1:0] last_addr;
  logic              last_sel;
  logic              last_wp;
  int                age;
  int                inval;
  initial
  begin
    foreach (mem[i]) mem[i] = ERASED;
    dev_q = 8'h00;
    age = 0;
    inval = 0;
  end
  always @(posedge clk)
  begin
    last_addr <= pins.word_address;
    last_sel <= pins.select_n;
    last_wp <= pins.write_pulse;
    age <= (pins.word_address != last_addr || pins.select_n != last_sel) ? 0 : age + 1;
    inval <= pins.write_mode_enable ? INVALID_CYC : (inval > 0 ? inval - 1 : 0);
    // one pulse clears the bits here; real parts need the full pass count
    if (pins.write_mode_enable && pins.write_pulse && !last_wp)
      mem[pins.word_address] <= mem[pins.word_address] & data_lines;
    // released lines toggle so a stale byte never reads as good
    if (pins.write_mode_enable || pins.select_n || age < READ_CYC - 1 || inval > 0)
      dev_q <= ~dev_q;
    else
      dev_q <= mem[pins.word_address];
  end
endmodule
`default_nettype wire

// ==== verif/test_uvep_host.sv ====
// self-checking bench: reads, a partial programming pass, reset mid-run
`timescale 1ns/1ps
`default_nettype none
module test_uvep_host;
  import uvep_pkg::*;
  logic              clk, srst, rd_req, prog_start, rd_valid, img_req, busy, prog_done, last_wp;
  logic [ADDR_W-1:0] rd_addr, img_addr;
  logic [DATA_W-1:0] rd_data, img_data, dev_q, data_lines;
  uvep_pins_t        pins;
  logic [18:0]       rq[$], pq[$];
  logic [31:0]       rs;
  int                err_total, total_checks, falls, n;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [DATA_W-1:0] img(input logic [ADDR_W-1:0] a);
    return 8'hA5 ^ a[7:0];
  endfunction
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd_one(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int k;
    k = 0;
    rq.push_back({11'h000, e});
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_req <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0 && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 200)
    begin
      err_total++;
      $display("mismatch at %0t: read never finished", $time);
    end
  endtask
  // data wire: host drives it only while its enable is low
  assign data_lines = pins.data_oe_n ? dev_q : pins.data_out;
  assign img_data = img(img_addr);
  uvep_host #(.PULSE_CYCLES(4), .SETUP_CYCLES(2), .INVALID_CYCLES(2), .LOOPS(1)) uut (
    .clk(clk), .srst(srst), .ce(1'b1), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .prog_start(prog_start), .img_req(img_req),
    .img_addr(img_addr), .img_data(img_data), .busy(busy), .prog_done(prog_done),
    .pins(pins), .data_lines_in(data_lines));
  uvep_dev dev (.clk(clk), .pins(pins), .data_lines(data_lines), .dev_q(dev_q));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    last_wp <= pins.write_pulse;
    if (pins.write_pulse === 1'b0 && last_wp === 1'b1)
      falls++;
    if (rd_valid === 1'b1)
      chk({11'h000, rd_data}, rq.size() ? rq.pop_front() : 19'h7FFFF);
    if (img_req === 1'b1)
      chk({img_addr, 8'h00}, pq.size() ? {pq[0][18:8], 8'h00} : 19'h7FFFF);
    if (pins.write_pulse === 1'b1 && last_wp !== 1'b1)
      chk({pins.word_address, pins.data_out}, pq.size() ? pq.pop_front() : 19'h7FFFF);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done;
  end
  initial
  begin
    srst = 1'b1;
    rd_req = 1'b0;
    rd_addr = '0;
    prog_start = 1'b0;
    last_wp = 1'b0;
    rs = 32'h1511;
    err_total = 0;
    total_checks = 0;
    falls = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_one(ADDR_ZERO, ERASED);
    rd_one(ADDR_LAST, ERASED);
    for (int i = 0; i < 3; i++)
    begin
      rs = xs(rs);
      rd_one(rs[ADDR_W-1:0], ERASED);
    end
    $display("test erased reads done");
    for (int k = 0; k < 4; k++)
      pq.push_back({ADDR_W'(k), img(ADDR_W'(k))});
    prog_start <= 1'b1;
    @(posedge clk) prog_start <= 1'b0;
    n = 0;
    while (falls < 4 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      err_total++;
      $display("mismatch at %0t: pulses never came", $time);
    end
    chk({18'h00000, pq.size() != 0}, 19'h00000);
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({15'h0000, pins.select_n, pins.write_pulse, pins.write_mode_enable, pins.data_oe_n},
      19'h00009);
    repeat (INVALID_CYC + 10) @(posedge clk);
    $display("test partial pass done");
    for (int k = 0; k < 4; k++)
      rd_one(ADDR_W'(k), img(ADDR_W'(k)));
    rd_one(ADDR_W'(4), ERASED);
    $display("test readback done");
    test_done;
  end
endmodule
`default_nettype wire
